//--- common/pcw_pkg.sv
// Constants for the indirect configuration and I/O window into the PCI bus
// What this block does
// - The address register holds bus in bits 23:16, device in 15:11 and function in 10:8.
// - The register field in bits 7:0 is word aligned and its two low bits read back as zero.
// - Bus zero gives a type 0 config cycle with at most one select bit, function, register and 00.
// - Devices 0-15 select AD16-31, devices 16-20 select AD11-15, devices 21-31 select none.
// - Any other bus copies address bits 31:2 to AD31:2 with AD1:0 set to 01 (type 1).
// - Bus 0, device and function all ones, register zero turns a config window write into a special cycle.
// - An unanswered config cycle ends in master abort and a read returns all ones.
// - A master abort on a config cycle never raises the fatal error output.
// - Config data and byte enables are byte swapped between host and PCI.
// - The address register is never swapped; the PCI address is built from its fields.
// - I/O cycles use only address bits 15:0 and move one word or less.
// - I/O window data is byte swapped like config data.
// - I/O cycles carry the byte address in AD1:0; the byte enables come from the host, unchecked against it.
package pcw_pkg;
   // -----------------------------------------------------------------
   // Register offsets
   // -----------------------------------------------------------------
   localparam logic [11:0] OFS_TARGET_ADDR = 12'h064;
   localparam logic [11:0] OFS_CFG_DATA    = 12'h068;
   localparam logic [11:0] OFS_IO_DATA     = 12'h06c;
   localparam logic [31:0] RST_TARGET_ADDR = 32'h0000_0000;

   // -----------------------------------------------------------------
   // Address register field positions
   // -----------------------------------------------------------------
   localparam int BUS_MSB  = 23;
   localparam int BUS_LSB  = 16;
   localparam int SLOT_MSB = 15;
   localparam int SLOT_LSB = 11;
   localparam int FUNC_MSB = 10;
   localparam int FUNC_LSB = 8;
   localparam int REGN_MSB = 7;
   localparam int REGN_LSB = 2;
   localparam int IO_MSB   = 15;
   localparam logic [31:0] READ_MASK   = 32'h00ff_fffc;
   localparam logic [7:0]  OWN_BUS     = 8'h00;
   localparam logic [4:0]  SLOT_ALL    = 5'h1f;
   localparam logic [2:0]  FUNC_ALL    = 3'h7;
   localparam logic [4:0]  SLOT_HI_LIM = 5'h10;
   localparam logic [4:0]  SLOT_NONE   = 5'h15;
   localparam logic [1:0]  TYPE0_LOW   = 2'h0;
   localparam logic [1:0]  TYPE1_LOW   = 2'h1;
   localparam logic [31:0] ALL_ONES    = 32'hffff_ffff;

   // -----------------------------------------------------------------
   // PCI command codes
   // -----------------------------------------------------------------
   localparam logic [3:0] CMD_SPECIAL = 4'h1;
   localparam logic [3:0] CMD_IO_RD   = 4'h2;
   localparam logic [3:0] CMD_IO_WR   = 4'h3;
   localparam logic [3:0] CMD_CFG_RD  = 4'ha;
   localparam logic [3:0] CMD_CFG_WR  = 4'hb;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_PCI,
      ST_ACK
   } pcw_state_t;
endpackage

//--- logic/pcw_cfg_addr.sv
// Builds the PCI configuration address and command from the address register
`timescale 1ns/1ps
module pcw_cfg_addr
   import pcw_pkg::*;
(
   input  wire logic [31:0] i_target,
   input  wire logic        i_write,
   output logic      [31:0] o_addr,
   output logic      [3:0]  o_cmd
);
   logic [7:0] bus;
   logic [4:0] slot;
   logic [2:0] func;
   logic [7:0] regn;

   assign bus  = i_target[BUS_MSB:BUS_LSB];
   assign slot = i_target[SLOT_MSB:SLOT_LSB];
   assign func = i_target[FUNC_MSB:FUNC_LSB];
   assign regn = {i_target[REGN_MSB:REGN_LSB], 2'h0};

   // At most one select bit for a type 0 cycle from the slot number
   function automatic logic [20:0] slot_select(input logic [4:0] s);
      logic [20:0] sel;
      sel = 21'h0;
      if (s < SLOT_HI_LIM) begin
         sel[5'(s + 5'd5)] = 1'b1;
      end else if (s < SLOT_NONE) begin
         sel[5'(s - SLOT_HI_LIM)] = 1'b1;
      end
      return sel;
   endfunction

   // Address type and command selection, fields taken unswapped
   always_comb begin
      if (bus == OWN_BUS) begin
         o_addr = {slot_select(slot), func, regn[7:2], TYPE0_LOW};
      end else begin
         o_addr = {i_target[31:2], TYPE1_LOW};
      end
      o_cmd = i_write ? CMD_CFG_WR : CMD_CFG_RD;
      if (i_write && bus == OWN_BUS && slot == SLOT_ALL && func == FUNC_ALL
          && regn == 8'h00) begin
         o_cmd = CMD_SPECIAL;
      end
   end
endmodule

//--- logic/pcw_window.sv
// Indirect configuration and I/O window from host registers to PCI cycles
`timescale 1ns/1ps
module pcw_window
   import pcw_pkg::*;
#(
   parameter int ADDR_W = 12
)(
   input  wire logic        I_MCLK,
   input  wire logic        I_RESETN,
   input  wire logic [ADDR_W-1:0] I_REG_ADDR,
   input  wire logic        I_REG_WR,
   input  wire logic        I_REG_RD,
   input  wire logic [31:0] I_REG_WDATA,
   input  wire logic [3:0]  I_REG_BE_N,
   output logic      [31:0] O_REG_RDATA,
   output logic             O_REG_ACK,
   output logic             O_BUSY,
   output logic             O_PCI_REQ,
   output logic      [3:0]  O_PCI_CMD,
   output logic      [31:0] O_PCI_ADDR,
   output logic      [31:0] O_PCI_WDATA,
   output logic      [3:0]  O_PCI_BE_N,
   input  wire logic        I_PCI_DONE,
   input  wire logic        I_PCI_MABORT,
   input  wire logic [31:0] I_PCI_RDATA,
   output logic             O_FATAL_ERR
);
   import pcw_pkg::*;

   // -----------------------------------------------------------------
   // Elaboration checks
   // -----------------------------------------------------------------
   // The offset decode needs twelve address bits
   if (ADDR_W < 12) begin : g_bad_width
      $error("ADDR_W must be at least 12");
   end

   // -----------------------------------------------------------------
   // Declarations
   // -----------------------------------------------------------------
   pcw_state_t  state_q;
   logic [31:0] target_q;
   logic        is_io_q;
   logic        is_rd_q;
   logic [31:0] cfg_addr;
   logic [3:0]  cfg_cmd;
   logic        req_any;
   logic [11:0] ofs;
   logic        hit_tgt;
   logic        hit_cfg;
   logic        hit_io;
   logic        hit_win;

   // Reverse byte lanes between big-endian host and little-endian PCI
   function automatic logic [31:0] swap32(input logic [31:0] d);
      return {d[7:0], d[15:8], d[23:16], d[31:24]};
   endfunction

   // Same reversal for the active-low byte enables
   function automatic logic [3:0] swap4(input logic [3:0] b);
      return {b[0], b[1], b[2], b[3]};
   endfunction

   // -----------------------------------------------------------------
   // Host request decode
   // -----------------------------------------------------------------
   // Offset decode, upper address bits ignored
   assign ofs     = I_REG_ADDR[11:0];
   // Strobes outside idle are dropped; the host must wait for the ack
   assign req_any = (I_REG_WR || I_REG_RD) && state_q == ST_IDLE;
   assign hit_tgt = ofs == OFS_TARGET_ADDR;
   assign hit_cfg = ofs == OFS_CFG_DATA;
   assign hit_io  = ofs == OFS_IO_DATA;
   // Either data window, both of which need a PCI cycle
   assign hit_win = hit_cfg || hit_io;

   // -----------------------------------------------------------------
   // Configuration address build
   // -----------------------------------------------------------------
   // Fed from the stored register so the address is ready at the taking edge
   pcw_cfg_addr u_cfg_addr (
      .i_target (target_q),
      .i_write  (I_REG_WR),
      .o_addr   (cfg_addr),
      .o_cmd    (cfg_cmd)
   );

   // -----------------------------------------------------------------
   // Address register
   // -----------------------------------------------------------------
   // Stored as written, never swapped
   // Reserved and low register bits are kept and only masked on read-back
   always_ff @(posedge I_MCLK) begin
      if (!I_RESETN) begin
         target_q <= RST_TARGET_ADDR;
      end else if (req_any && I_REG_WR && hit_tgt) begin
         target_q <= I_REG_WDATA;
      end
   end

   // -----------------------------------------------------------------
   // Access sequencer
   // -----------------------------------------------------------------
   // Window accesses wait in ST_PCI for the cycle to end, others ack at once
   // The ack cycle is spent in ST_ACK, not idle, so no strobe is taken with it
   always_ff @(posedge I_MCLK) begin
      if (!I_RESETN) begin
         state_q <= ST_IDLE;
      end else begin
         unique case (state_q)
            ST_IDLE: begin
               if (req_any) begin
                  state_q <= hit_win ? ST_PCI : ST_ACK;
               end
            end
            ST_PCI: begin
               if (I_PCI_DONE) begin
                  state_q <= ST_ACK;
               end
            end
            ST_ACK: begin
               state_q <= ST_IDLE;
            end
            // The fourth code is never entered; recover to idle if it is
            default: begin
               state_q <= ST_IDLE;
            end
         endcase
      end
   end

   // Kind of the access in flight
   // Kept for the answer, since the strobes are gone by then
   always_ff @(posedge I_MCLK) begin
      if (!I_RESETN) begin
         is_io_q <= 1'b0;
         is_rd_q <= 1'b0;
      end else if (req_any) begin
         is_io_q <= hit_io;
         is_rd_q <= I_REG_RD;
      end
   end

   // -----------------------------------------------------------------
   // PCI cycle request
   // -----------------------------------------------------------------
   // Request held from the cycle after the access until done
   // Cycle fields are captured at the taking edge and held while requested,
   // so a later host write cannot change a cycle in flight
   // I/O cycles take the low half of the address register as a byte address
   always_ff @(posedge I_MCLK) begin
      if (!I_RESETN) begin
         O_PCI_REQ   <= 1'b0;
         O_PCI_CMD   <= 4'h0;
         O_PCI_ADDR  <= 32'h0000_0000;
         O_PCI_WDATA <= 32'h0000_0000;
         O_PCI_BE_N  <= 4'hf;
      end else if (req_any && hit_cfg) begin
         O_PCI_REQ   <= 1'b1;
         O_PCI_CMD   <= cfg_cmd;
         O_PCI_ADDR  <= cfg_addr;
         O_PCI_WDATA <= swap32(I_REG_WDATA);
         O_PCI_BE_N  <= swap4(I_REG_BE_N);
      end else if (req_any && hit_io) begin
         O_PCI_REQ   <= 1'b1;
         O_PCI_CMD   <= I_REG_WR ? CMD_IO_WR : CMD_IO_RD;
         O_PCI_ADDR  <= {16'h0000, target_q[IO_MSB:0]};
         O_PCI_WDATA <= swap32(I_REG_WDATA);
         O_PCI_BE_N  <= swap4(I_REG_BE_N);
      end else if (state_q == ST_PCI && I_PCI_DONE) begin
         O_PCI_REQ   <= 1'b0;
      end
   end

   // -----------------------------------------------------------------
   // Host answer
   // -----------------------------------------------------------------
   // Read data and ack; aborted reads give all ones
   // Window writes answer zero so old read data never looks fresh
   always_ff @(posedge I_MCLK) begin
      if (!I_RESETN) begin
         O_REG_RDATA <= 32'h0000_0000;
         O_REG_ACK   <= 1'b0;
      end else begin
         O_REG_ACK <= 1'b0;
         if (req_any && !hit_win) begin
            O_REG_ACK   <= 1'b1;
            O_REG_RDATA <= (I_REG_RD && hit_tgt) ? (target_q & READ_MASK) : 32'h0;
         end else if (state_q == ST_PCI && I_PCI_DONE) begin
            O_REG_ACK <= 1'b1;
            if (!is_rd_q) begin
               O_REG_RDATA <= 32'h0000_0000;
            end else if (I_PCI_MABORT) begin
               O_REG_RDATA <= ALL_ONES;
            end else begin
               O_REG_RDATA <= swap32(I_PCI_RDATA);
            end
         end
      end
   end

   // Busy shows a window access waiting on PCI
   // It falls at the same edge that raises the ack
   always_ff @(posedge I_MCLK) begin
      if (!I_RESETN) begin
         O_BUSY <= 1'b0;
      end else begin
         O_BUSY <= (req_any && hit_win)
                   || (state_q == ST_PCI && !I_PCI_DONE);
      end
   end

   // Fatal error only for aborted I/O cycles, never config
   // Bus walking aborts config cycles on empty slots, so they stay harmless
   always_ff @(posedge I_MCLK) begin
      if (!I_RESETN) begin
         O_FATAL_ERR <= 1'b0;
      end else if (state_q == ST_PCI && I_PCI_DONE && I_PCI_MABORT && is_io_q) begin
         O_FATAL_ERR <= 1'b1;
      end
   end
endmodule

//--- tb/pcw_window_monitor.sv
// Concurrent checks on the host and PCI ports of the window
`timescale 1ns/1ps
module pcw_window_monitor
   import pcw_pkg::*;
#(parameter int ADDR_W = 12)(
   input wire logic              I_MCLK,
   input wire logic              I_RESETN,
   input wire logic [ADDR_W-1:0] I_REG_ADDR,
   input wire logic              I_REG_WR,
   input wire logic              I_REG_RD,
   input wire logic [31:0]       I_REG_WDATA,
   input wire logic [31:0]       O_REG_RDATA,
   input wire logic              O_REG_ACK,
   input wire logic              O_BUSY,
   input wire logic              O_PCI_REQ,
   input wire logic [3:0]        O_PCI_CMD,
   input wire logic [31:0]       O_PCI_ADDR,
   input wire logic              I_PCI_DONE,
   input wire logic              I_PCI_MABORT,
   input wire logic [31:0]       I_PCI_RDATA,
   input wire logic              O_FATAL_ERR
);
   logic [31:0] tgt_q;
   wire logic idle = !O_BUSY && !O_REG_ACK;
   wire logic [31:0] rd_sw = {I_PCI_RDATA[7:0], I_PCI_RDATA[15:8],
                              I_PCI_RDATA[23:16], I_PCI_RDATA[31:24]};
   // Shadow of the address register, loaded by accepted writes
   always_ff @(posedge I_MCLK) begin
      if (!I_RESETN) tgt_q <= '0;
      else if (idle && I_REG_WR && I_REG_ADDR == OFS_TARGET_ADDR) tgt_q <= I_REG_WDATA;
   end
   default clocking @(posedge I_MCLK); endclocking
   default disable iff (!I_RESETN);
   sequence s_end; O_PCI_REQ && I_PCI_DONE; endsequence
   sequence s_ack; !O_PCI_REQ && O_REG_ACK && !O_BUSY; endsequence
   req_hold_a: assert property (O_PCI_REQ && !I_PCI_DONE |=>
      O_PCI_REQ && $stable(O_PCI_ADDR)) else $error("request not held");
   end_ack_a: assert property (s_end |=> s_ack) else $error("no answer after done");
   abort_ones_a: assert property (s_end ##0 (I_PCI_MABORT && !O_PCI_CMD[0]) |=>
      O_REG_RDATA == ALL_ONES) else $error("abort read not all ones");
   rd_swap_a: assert property (s_end ##0 (!I_PCI_MABORT && !O_PCI_CMD[0]) |=>
      O_REG_RDATA == $past(rd_sw)) else $error("read data not swapped");
   no_fatal_a: assert property (s_end ##0 (I_PCI_MABORT && O_PCI_CMD[3] && !O_FATAL_ERR)
      |=> !O_FATAL_ERR) else $error("fatal on config abort");
   type0_adr_a: assert property ($rose(O_PCI_REQ) && O_PCI_CMD[3:1] == 3'h5 &&
      tgt_q[23:16] == OWN_BUS |-> O_PCI_ADDR[10:0] == {tgt_q[10:2], TYPE0_LOW})
      else $error("type 0 address wrong");
   type1_adr_a: assert property ($rose(O_PCI_REQ) && O_PCI_CMD[3:1] == 3'h5 &&
      tgt_q[23:16] != OWN_BUS |-> O_PCI_ADDR == {tgt_q[31:2], TYPE1_LOW})
      else $error("type 1 address wrong");
   io_adr_a: assert property ($rose(O_PCI_REQ) && O_PCI_CMD[3:1] == 3'h1 |->
      O_PCI_ADDR == {16'h0, tgt_q[15:0]}) else $error("io address wrong");
   special_a: assert property ($rose(O_PCI_REQ) && tgt_q[23:0] == 24'h00ff00 |->
      O_PCI_CMD != CMD_CFG_WR) else $error("special address gave config write");
   addr_read_a: assert property (idle && I_REG_RD && I_REG_ADDR == OFS_TARGET_ADDR |=>
      O_REG_ACK && O_REG_RDATA == (tgt_q & READ_MASK)) else $error("address readback wrong");
   busy_win_a: assert property (idle && (I_REG_WR || I_REG_RD) &&
      (I_REG_ADDR == OFS_CFG_DATA || I_REG_ADDR == OFS_IO_DATA) |=>
      O_BUSY && O_PCI_REQ && !O_REG_ACK) else $error("window access not held off");
endmodule
bind pcw_window pcw_window_monitor #(.ADDR_W(ADDR_W)) u_mon (.*);

//--- tb/pcw_pci_target.sv
// PCI target model answering the window's cycles after a set latency
`timescale 1ns/1ps
module pcw_pci_target (
   input  wire logic        i_clk,
   input  wire logic        i_rst_n,
   input  wire logic        i_req,
   input  wire logic [3:0]  i_cmd,
   input  wire logic [31:0] i_addr,
   input  wire logic [31:0] i_wdata,
   input  wire logic [3:0]  i_lat,
   input  wire logic        i_abort,
   output logic             o_done,
   output logic             o_mabort,
   output logic      [31:0] o_rdata
);
   logic [31:0] mem [16];
   logic [3:0]  cnt_q;
   // Wait i_lat cycles, then end the cycle; data lines toggle when not valid
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         mem      <= '{default: 32'h0};
         cnt_q    <= 4'h0;
         o_done   <= 1'h0;
         o_mabort <= 1'h0;
         o_rdata  <= 32'h0;
      end else if (i_req && !o_done && cnt_q == i_lat) begin
         o_done   <= 1'h1;
         o_mabort <= i_abort;
         o_rdata  <= i_abort ? ~o_rdata : mem[i_addr[5:2]];
         if (i_cmd[0] && !i_abort) mem[i_addr[5:2]] <= i_wdata;
         cnt_q    <= 4'h0;
      end else begin
         o_done   <= 1'h0;
         o_mabort <= 1'h0;
         o_rdata  <= ~o_rdata;
         cnt_q    <= (i_req && !o_done) ? cnt_q + 4'h1 : 4'h0;
      end
   end
endmodule

//--- tb/pcw_window_tb.sv
// Self-checking bench for the configuration and I/O window
`timescale 1ns/1ps
module pcw_window_tb;
   import pcw_pkg::*;
   logic clk = 1'h0, rstn = 1'h0, wr = 1'h0, rd = 1'h0, abort = 1'h0;
   logic ack, busy, req, done, mab, fatal;
   logic [11:0] adr = 12'h0;
   logic [3:0]  be_n = 4'h0, lat = 4'h0, cmd, pbe, s_cmd, s_be;
   logic [31:0] wd = 32'h0, rdat, padr, pwd, prd, s_adr, s_wd, got;
   int          error_cnt = 0, n_compared = 0;
   always #10 clk = ~clk;
   pcw_window DUT (.I_MCLK(clk), .I_RESETN(rstn), .I_REG_ADDR(adr), .I_REG_WR(wr),
      .I_REG_RD(rd), .I_REG_WDATA(wd), .I_REG_BE_N(be_n), .O_REG_RDATA(rdat), .O_REG_ACK(ack),
      .O_BUSY(busy), .O_PCI_REQ(req), .O_PCI_CMD(cmd), .O_PCI_ADDR(padr), .O_PCI_WDATA(pwd),
      .O_PCI_BE_N(pbe), .I_PCI_DONE(done), .I_PCI_MABORT(mab), .I_PCI_RDATA(prd),
      .O_FATAL_ERR(fatal));
   pcw_pci_target tgt (.i_clk(clk), .i_rst_n(rstn), .i_req(req), .i_cmd(cmd), .i_addr(padr),
      .i_wdata(pwd), .i_lat(lat), .i_abort(abort), .o_done(done), .o_mabort(mab), .o_rdata(prd));
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_compared++;
      if (g !== e) begin
         error_cnt++;
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   // One register access; strobe for a cycle, snapshot the PCI cycle, wait for the answer
   task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d,
                      input logic [3:0] b);
      @(negedge clk);
      {wr, rd, adr, wd, be_n} = {w, !w, a, d, b};
      @(negedge clk);
      {wr, rd} = 2'h0;
      for (int i = 0; i < 40 && ack !== 1'h1; i++) begin
         if (req === 1'h1) {s_cmd, s_adr, s_wd, s_be} = {cmd, padr, pwd, pbe};
         @(negedge clk);
      end
      chk({31'h0, ack}, 32'h1);
      got = rdat;
   endtask
   task automatic t_areg();
      acc(1'h1, OFS_TARGET_ADDR, 32'h00ab_cd57, 4'h0);
      acc(1'h0, OFS_TARGET_ADDR, 32'h0, 4'h0);
      chk(got, 32'h00ab_cd54);
      acc(1'h0, 12'h070, 32'h0, 4'h0);
      chk(got, 32'h0);
      $display("test address register done");
   endtask
   task automatic t_type0();
      logic [31:0] e;
      for (int d = 0; d < 32; d++) begin
         e = d < 16 ? 32'h1 << (16 + d) : d < 21 ? 32'h1 << (d - 5) : 32'h0;
         acc(1'h1, OFS_TARGET_ADDR, {16'h0, d[4:0], 11'h23c}, 4'h0);
         acc(1'h0, OFS_CFG_DATA, 32'h0, 4'h0);
         chk(s_adr, e | 32'h0000_023c);
         chk({28'h0, s_cmd}, {28'h0, CMD_CFG_RD});
      end
      $display("test type 0 select done");
   endtask
   task automatic t_type1();
      lat = 4'h3;
      acc(1'h1, OFS_TARGET_ADDR, 32'h0005_1004, 4'h0);
      acc(1'h1, OFS_CFG_DATA, 32'h7856_3412, 4'h1);
      chk(s_adr, 32'h0005_1005);
      chk({28'h0, s_cmd}, {28'h0, CMD_CFG_WR});
      chk(s_wd, 32'h1234_5678);
      chk({28'h0, s_be}, 32'h8);
      acc(1'h0, OFS_CFG_DATA, 32'h0, 4'h0);
      chk(got, 32'h7856_3412);
      acc(1'h1, OFS_TARGET_ADDR, 32'h0000_ff00, 4'h0);
      acc(1'h1, OFS_CFG_DATA, 32'h1, 4'h0);
      chk({28'h0, s_cmd}, {28'h0, CMD_SPECIAL});
      acc(1'h0, OFS_CFG_DATA, 32'h0, 4'h0);
      chk({28'h0, s_cmd}, {28'h0, CMD_CFG_RD});
      $display("test type 1 and special done");
   endtask
   task automatic t_io();
      logic [1:0]  lo [7] = '{2'h0, 2'h2, 2'h0, 2'h0, 2'h1, 2'h2, 2'h3};
      logic [3:0]  hb [7] = '{4'h0, 4'hc, 4'h3, 4'h7, 4'hb, 4'hd, 4'he};
      logic [3:0]  rb;
      logic [31:0] v, sw;
      lat = 4'h1;
      for (int k = 0; k < 7; k++) begin
         v = 32'h1122_3344 + k;
         sw = {<<8{v}};
         rb = {<<{hb[k]}};
         acc(1'h1, OFS_TARGET_ADDR, {16'h0012, 14'h048d, lo[k]}, 4'h0);
         acc(1'h1, OFS_IO_DATA, v, hb[k]);
         chk(s_adr, {16'h0, 14'h048d, lo[k]});
         chk({28'h0, s_cmd}, {28'h0, CMD_IO_WR});
         chk({28'h0, s_be}, {28'h0, rb});
         chk(s_wd, sw);
         acc(1'h0, OFS_IO_DATA, 32'h0, hb[k]);
         chk(got, v);
         chk({28'h0, s_cmd}, {28'h0, CMD_IO_RD});
      end
      $display("test io window done");
   endtask
   task automatic t_abort();
      abort = 1'h1;
      acc(1'h1, OFS_TARGET_ADDR, 32'h0009_0800, 4'h0);
      acc(1'h0, OFS_CFG_DATA, 32'h0, 4'h0);
      chk(got, ALL_ONES);
      acc(1'h1, OFS_CFG_DATA, 32'h5, 4'h0);
      chk({31'h0, fatal}, 32'h0);
      acc(1'h0, OFS_IO_DATA, 32'h0, 4'h0);
      chk({31'h0, fatal}, 32'h1);
      chk(got, ALL_ONES);
      $display("test master abort done");
   endtask
   // Reset in mid-run clears the sticky error and the address register
   task automatic t_reset();
      @(negedge clk);
      rstn = 1'h0;
      repeat (2) @(negedge clk);
      rstn = 1'h1;
      chk({30'h0, busy, fatal}, 32'h0);
      acc(1'h0, OFS_TARGET_ADDR, 32'h0, 4'h0);
      chk(got, RST_TARGET_ADDR);
      $display("test reset done");
   endtask
   task automatic end_of_test();
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   initial begin
      repeat (16) @(negedge clk);
      rstn = 1'h1;
      t_areg();
      t_type0();
      t_type1();
      t_io();
      t_abort();
      t_reset();
      end_of_test();
   end
   // Watchdog well beyond the few hundred cycles the tests need
   initial begin
      #400_000;
      error_cnt++;
      end_of_test();
   end
endmodule
